// ===== verilog/power_and_loop_mode_control.sv
// power-down and loop mode control bank behind an Avalon-MM slave
// assumes a master on ref_clk_i, 32-bit data, word addresses in bytes
//
// Operation
// - bit 7 soft-resets logic, registers kept
// - bit 6 puts oscillator in deep sleep
// - bit 5 sleeps system clock and multiplier
// - bit 4 sleeps all reference receivers
// - bit 3 sleeps time-to-digital converter
// - bit 2 sleeps output synthesizer loop
// - bit 1 sleeps clock distribution outputs
// - bit 0 sleeps everything, overriding others
// - loop bit 6 forces holdover, history first
// - loop bit 5 forces user free run
// - free run beats holdover when both set
// - bits 4:2 select reference switchover policy
// - full manual: bit 0 picks reference
`timescale 1ns/1ps
`default_nettype none
`include "loop_ctrl_regs.svh"

module power_and_loop_mode_control (
  input  wire logic        ref_clk_i,            // 20 MHz system clock
  input  wire logic        nrst_i,               // synchronous reset, active low
  // avalon-mm slave
  input  wire logic [13:0] address,              // byte address
  input  wire logic        read,                 // read request
  input  wire logic        write,                // write request
  input  wire logic [31:0] writedata,            // write data
  input  wire logic [3:0]  byteenable,           // lane 0 carries the register
  output logic [31:0]      readdata,             // read data, registered
  output logic             waitrequest,          // high until answer
  output logic [1:0]       response,             // 00 okay, 10 slave error
  // loop state
  input  wire logic        history_valid_i,      // tuning word history present
  // subsystem controls
  output logic             soft_rst_o,           // logic reset, registers kept
  output logic             osc_sleep_o,          // controlled_oscillator sleep
  output logic             system_clock_input_sleep_o,       // system_clock_input and multiplier
  output logic             ref_sleep_o,          // reference receivers
  output logic             tdc_sleep_o,          // time_to_digital_converter
  output logic             synth_sleep_o,        // output_synth_loop
  output logic             dist_sleep_o,         // distribution outputs
  output logic             full_sleep_o,         // whole device
  output logic [2:0]       loop_mode_o,          // one-hot track, hold, free
  output logic             use_history_o,        // holdover uses history word
  output logic [2:0]       switch_policy_o,      // switchover policy code
  output logic             second_ref_sel_o      // second_reference_input in full manual
);

  // =====================================================
  // state
  typedef struct packed {
    logic [7:0]  pd;    // power_down_control
    logic [7:0]  lm;    // loop_mode_control
    logic        ack;   // answer cycle
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic        sr_req;
  } bank_t;

  bank_t s_q;
  bank_t s_d;

  logic sr_busy;  // soft reset pulse active
  logic sr_done;  // soft reset finished

  // decode of a register address, used for reads and writes
  function automatic logic [1:0] decode(input logic [13:0] a);
    case (a)
      `PWR_DOWN_ADDR:  decode = 2'h1;
      `LOOP_MODE_ADDR: decode = 2'h2;
      `STATUS_ADDR:    decode = 2'h3;
      default:         decode = 2'h0;
    endcase
  endfunction

  // effective loop mode; free run wins so the two never fight
  function automatic loop_ctrl_pkg::loop_mode_t mode_of(input logic [7:0] lm);
    if (lm[`LM_FREE]) begin
      mode_of = loop_ctrl_pkg::LOOP_FREE;
    end else if (lm[`LM_HOLD]) begin
      mode_of = loop_ctrl_pkg::LOOP_HOLD;
    end else begin
      mode_of = loop_ctrl_pkg::LOOP_TRACK;
    end
  endfunction

  // =====================================================
  // bus and register next state
  // one wait cycle: request is taken, answer flagged the next cycle
  always_comb begin
    s_d        = s_q;
    s_d.ack    = 1'b0;
    s_d.sr_req = 1'b0;
    if ((read || write) && !s_q.ack) begin
      s_d.ack   = 1'b1;
      s_d.resp  = (decode(address) == 2'h0) ? 2'h2 : 2'h0;
      s_d.rdata = 32'h0000_0000;
      if (read) begin
        case (decode(address))
          2'h1: s_d.rdata = {24'h00_0000, s_q.pd};
          2'h2: s_d.rdata = {24'h00_0000, s_q.lm};
          2'h3: s_d.rdata = {24'h00_0000, 5'h00, mode_of(s_q.lm)} | {23'h00_0000, sr_busy, 8'h00};
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end else if (byteenable[0]) begin
        case (decode(address))
          2'h1: begin
            s_d.pd = writedata[7:0];
            // soft reset bit is a request; it clears itself when done
            if (writedata[`PD_SOFT_RST] && !sr_busy) begin
              s_d.sr_req = 1'b1;
            end
          end
          // reserved bits 7 and 1 are kept zero by the mask
          2'h2: s_d.lm = writedata[7:0] & `LM_WMASK;
          default: s_d.lm = s_q.lm;
        endcase
      end
    end
    // soft reset does not touch register contents, only clears its own bit;
    // a fresh trigger written in the done cycle wins over the self-clear
    if (sr_done && !s_d.sr_req) begin
      s_d.pd[`PD_SOFT_RST] = 1'b0;
    end
  end

  // register
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s_q <= '{pd: `PD_RESET, lm: `LM_RESET, ack: 1'b0,
               rdata: 32'h0000_0000, resp: 2'h0, sr_req: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // soft reset pulse stretcher
  soft_rst_gen #(
    .PULSE_CYC (`SOFT_RST_CYC)
  ) u_soft_rst (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .req_i     (s_q.sr_req),
    .busy_o    (sr_busy),
    .done_o    (sr_done)
  );

  // =====================================================
  // outputs
  assign waitrequest = (read || write) && !s_q.ack;
  assign readdata    = s_q.rdata;
  assign response    = s_q.resp;
  assign soft_rst_o  = sr_busy;

  // full power-down forces every subsystem asleep
  assign full_sleep_o   = s_q.pd[`PD_FULL];
  assign osc_sleep_o    = s_q.pd[`PD_OSC]    | s_q.pd[`PD_FULL];
  assign system_clock_input_sleep_o = s_q.pd[`PD_SYSTEM_CLOCK_INPUT] | s_q.pd[`PD_FULL];
  assign ref_sleep_o    = s_q.pd[`PD_REF]    | s_q.pd[`PD_FULL];
  assign tdc_sleep_o    = s_q.pd[`PD_TDC]    | s_q.pd[`PD_FULL];
  assign synth_sleep_o  = s_q.pd[`PD_SYNTH]  | s_q.pd[`PD_FULL];
  assign dist_sleep_o   = s_q.pd[`PD_DIST]   | s_q.pd[`PD_FULL];

  assign loop_mode_o      = mode_of(s_q.lm);
  // holdover falls back to the free-run word when no history exists
  assign use_history_o    = (mode_of(s_q.lm) == loop_ctrl_pkg::LOOP_HOLD) && history_valid_i;
  assign switch_policy_o  = s_q.lm[`LM_SW_HI:`LM_SW_LO];
  // manual choice only matters in full manual mode
  assign second_ref_sel_o = (s_q.lm[`LM_SW_HI:`LM_SW_LO] == `SW_FULL_MANUAL) && s_q.lm[`LM_REF_SEL];

  // =====================================================
  // assertions
  full_forces_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    full_sleep_o |-> (osc_sleep_o && system_clock_input_sleep_o && ref_sleep_o && tdc_sleep_o && synth_sleep_o && dist_sleep_o))
    else $error("full sleep did not force all");
  osc_sleep_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    osc_sleep_o == (s_q.pd[`PD_OSC] || s_q.pd[`PD_FULL])) else $error("oscillator sleep wrong");
  system_clock_input_sleep_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_q.pd[`PD_SYSTEM_CLOCK_INPUT] |-> system_clock_input_sleep_o) else $error("system_clock_input sleep wrong");
  ref_sleep_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_q.pd[`PD_REF] |-> ref_sleep_o) else $error("reference sleep wrong");
  tdc_sleep_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_q.pd[`PD_TDC] |-> tdc_sleep_o) else $error("tdc sleep wrong");
  synth_sleep_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_q.pd[`PD_SYNTH] |-> synth_sleep_o) else $error("synth sleep wrong");
  dist_sleep_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_q.pd[`PD_DIST] |-> dist_sleep_o) else $error("distribution sleep wrong");
  free_wins_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_q.lm[`LM_FREE] |-> (loop_mode_o == loop_ctrl_pkg::LOOP_FREE)) else $error("free run lost");
  hold_mode_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (s_q.lm[`LM_HOLD] && !s_q.lm[`LM_FREE]) |-> (loop_mode_o == loop_ctrl_pkg::LOOP_HOLD))
    else $error("holdover not entered");
  manual_ref_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (switch_policy_o != `SW_FULL_MANUAL) |-> !second_ref_sel_o) else $error("manual select leaked");
  policy_field_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    switch_policy_o == s_q.lm[`LM_SW_HI:`LM_SW_LO]) else $error("policy field wrong");
  soft_rst_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_q.sr_req |=> soft_rst_o [*4] ##1 !soft_rst_o) else $error("soft reset pulse wrong");
  keep_regs_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (soft_rst_o && !write) |=> ($stable(s_q.lm) && $stable(s_q.pd[`PD_OSC:`PD_FULL])))
    else $error("soft reset touched registers");
  reset_zero_a: assert property (@(posedge ref_clk_i)
    !nrst_i |=> (s_q.pd == 8'h00 && s_q.lm == 8'h00)) else $error("reset value wrong");
  bus_answer_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ((read || write) && waitrequest) |=> !waitrequest) else $error("answer late");

  soft_rst_c: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) sr_done);
  both_force_c: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) s_q.lm[`LM_FREE] && s_q.lm[`LM_HOLD]);
  manual_b_c: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) second_ref_sel_o);
  full_sleep_c: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) full_sleep_o);

endmodule
`default_nettype wire

// ===== verilog/loop_ctrl_regs.svh
// register map and field positions of the power and loop mode control bank
// assumes inclusion from the design and bench files by bare name
`ifndef LOOP_CTRL_REGS_SVH
`define LOOP_CTRL_REGS_SVH

// printed offsets are not multiples of four: indexes, byte address = 4 * index
`define PWR_DOWN_IDX      12'ha00
`define LOOP_MODE_IDX     12'ha01
`define STATUS_IDX        12'ha02
`define ADDR_W            14
`define PWR_DOWN_ADDR     14'h2800
`define LOOP_MODE_ADDR    14'h2804
`define STATUS_ADDR       14'h2808

// power-down bits
`define PD_SOFT_RST       7
`define PD_OSC            6
`define PD_SYSTEM_CLOCK_INPUT         5
`define PD_REF            4
`define PD_TDC            3
`define PD_SYNTH          2
`define PD_DIST           1
`define PD_FULL           0

// loop mode fields
`define LM_HOLD           6
`define LM_FREE           5
`define LM_SW_HI          4
`define LM_SW_LO          2
`define LM_REF_SEL        0
`define LM_WMASK          8'h7d

`define PD_RESET          8'h00
`define LM_RESET          8'h00
`define SW_FULL_MANUAL    3'h4
`define SW_LAST_USED      3'h4

// soft reset pulse length in cycles
`define SOFT_RST_CYC      4'h4

`endif

// ===== verilog/loop_ctrl_pkg.sv
// types shared by the power and loop mode control bank
// assumes loop_ctrl_regs.svh for numeric constants
package loop_ctrl_pkg;

  // loop mode that the bank asks of the loop state machine
  typedef enum logic [2:0] {
    LOOP_TRACK = 3'h1,
    LOOP_HOLD  = 3'h2,
    LOOP_FREE  = 3'h4
  } loop_mode_t;

  // soft reset sequencer states, one-hot
  typedef enum logic [1:0] {
    SR_IDLE = 2'h1,
    SR_BUSY = 2'h2
  } soft_rst_state_t;

endpackage

// ===== verilog/soft_rst_gen.sv
// soft reset pulse generator: stretches a request into a fixed-length pulse
// assumes request from the register bank on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "loop_ctrl_regs.svh"

module soft_rst_gen #(
  parameter logic [3:0] PULSE_CYC = `SOFT_RST_CYC
) (
  input  wire logic ref_clk_i,  // system clock
  input  wire logic nrst_i,     // synchronous reset, active low
  input  wire logic req_i,      // one-cycle request
  output logic      busy_o,     // soft reset active
  output logic      done_o      // one-cycle pulse at end
);

  // =====================================================
  // state
  typedef struct packed {
    loop_ctrl_pkg::soft_rst_state_t st;  // sequencer state
    logic [3:0]                     cnt; // cycles left
    logic                           done;
  } sr_state_t;

  sr_state_t s_q;
  sr_state_t s_d;

  // next state: a request during a pulse restarts nothing, it is absorbed
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      loop_ctrl_pkg::SR_IDLE: begin
        if (req_i) begin
          s_d.st  = loop_ctrl_pkg::SR_BUSY;
          s_d.cnt = PULSE_CYC - 4'h1;
        end
      end
      loop_ctrl_pkg::SR_BUSY: begin
        if (s_q.cnt == 4'h0) begin
          s_d.st   = loop_ctrl_pkg::SR_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: s_d.st = loop_ctrl_pkg::SR_IDLE;
    endcase
  end

  // register
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s_q <= '{st: loop_ctrl_pkg::SR_IDLE, cnt: 4'h0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o = (s_q.st == loop_ctrl_pkg::SR_BUSY);
  assign done_o = s_q.done;

endmodule
`default_nettype wire

// ===== verif/power_and_loop_mode_control_bench.sv
// self-checking bench for the power and loop mode control bank
// assumes loop_ctrl_regs.svh and the design compiled first
`timescale 1ns/1ps
`default_nettype none
`include "loop_ctrl_regs.svh"

module power_and_loop_mode_control_bench;
  // ==========================================================
  // signals
  logic        ref_clk_i = 1'b0;   // 20 MHz clock
  logic        nrst_i = 1'b0;      // reset, active low
  logic [13:0] address = 14'h0;    // bus address
  logic        read = 1'b0;        // bus read
  logic        write = 1'b0;       // bus write
  logic [31:0] writedata = 32'h0;  // bus write data
  logic [3:0]  byteenable = 4'h0;  // bus lanes
  logic        history_valid_i = 1'b0;  // history present
  logic [31:0] readdata;           // bus read data
  logic        waitrequest;        // bus stall
  logic [1:0]  response;           // bus response
  logic [6:0]  sleep;              // osc down to full
  logic        soft_rst;           // soft reset pulse
  logic [2:0]  mode;               // loop mode one-hot
  logic        use_hist;           // holdover uses history
  logic [2:0]  policy;             // switchover policy
  logic        ref_sel;            // second reference chosen
  logic [33:0] exp_q[$];           // expected {response, readdata}
  int          n_fail = 0;         // mismatches
  int          n_checks = 0;       // comparisons
  int          k;                  // scratch
  logic [7:0]  v;                  // scratch value

  always #25 ref_clk_i = ~ref_clk_i;

  power_and_loop_mode_control i_dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .history_valid_i(history_valid_i),
    .soft_rst_o(soft_rst), .osc_sleep_o(sleep[6]), .system_clock_input_sleep_o(sleep[5]),
    .ref_sleep_o(sleep[4]), .tdc_sleep_o(sleep[3]), .synth_sleep_o(sleep[2]),
    .dist_sleep_o(sleep[1]), .full_sleep_o(sleep[0]), .loop_mode_o(mode),
    .use_history_o(use_hist), .switch_policy_o(policy), .second_ref_sel_o(ref_sel));

  // ==========================================================
  // reporting
  task automatic wrap_up();
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // read result against oldest note
  task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  // output levels against expectation
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: outputs %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // bus master: request held until waitrequest seen low
  task automatic bus(input logic wr, input logic [13:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge ref_clk_i);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= {24'($urandom()), d};  // upper lanes unused, kept busy anyway
    byteenable <= be;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      n_fail++;
      $display("Error at %0t: waitrequest %h expected %h", $time, waitrequest, 1'b0);
      wrap_up();
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // note the expected answer, then read
  task automatic rd(input logic [13:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00, 4'hf);
  endtask

  // expected {mode, history, policy, select} for a loop-mode value
  function automatic logic [7:0] lm_exp(input logic [7:0] m, input logic hv);
    logic [2:0] md;
    md = m[5] ? 3'h4 : (m[6] ? 3'h2 : 3'h1);
    return {md, md == 3'h2 && hv, m[4:2], m[4:2] == 3'h4 && m[0]};
  endfunction

  // ==========================================================
  // watcher: each read answer takes the oldest note
  always @(posedge ref_clk_i) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("Error at %0t: unnoted read %h expected %h", $time, {response, readdata}, 34'h0);
      end else begin
        chk_rd({response, readdata}, exp_q.pop_front());
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h73945e03));
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(negedge ref_clk_i);
    chk_out({1'b0, sleep}, 8'h00);
    chk_out({mode, use_hist, policy, ref_sel}, 8'h20);
    rd(`PWR_DOWN_ADDR, 34'h0);
    rd(`LOOP_MODE_ADDR, 34'h0);
    // walking bits, then random mixes; full sleep forces every output
    for (int i = 0; i < 11; i++) begin
      v = (i < 7) ? (8'h01 << i) : (8'($urandom()) & 8'h7f);
      bus(1'b1, `PWR_DOWN_ADDR, v, 4'h1);
      @(negedge ref_clk_i);
      chk_out({1'b0, sleep}, v[0] ? 8'h7f : v);
      rd(`PWR_DOWN_ADDR, {26'h0, v});
    end
    // lane 0 disabled: write must not land
    bus(1'b1, `PWR_DOWN_ADDR, 8'h00, 4'he);
    rd(`PWR_DOWN_ADDR, {26'h0, v});
    // policy codes 0 to 4 with random forcing bits and history
    for (int i = 0; i < 15; i++) begin
      v = (8'($urandom()) & 8'h61) | (8'(i % 5) << 2);
      if (i == 14) v = 8'h71;  // both forces, full manual, second reference
      history_valid_i <= 1'($urandom());
      bus(1'b1, `LOOP_MODE_ADDR, v, 4'h1);
      @(negedge ref_clk_i);
      chk_out({mode, use_hist, policy, ref_sel}, lm_exp(v, history_valid_i));
      rd(`LOOP_MODE_ADDR, {26'h0, v & `LM_WMASK});
    end
    // status shows the effective mode: free run beats holdover
    rd(`STATUS_ADDR, 34'h4);
    // soft reset: pulse of fixed length, register contents survive
    bus(1'b1, `PWR_DOWN_ADDR, 8'h84, 4'h1);
    k = 0;
    repeat (12) begin
      @(negedge ref_clk_i);
      if (soft_rst === 1'b1) k++;
    end
    chk_out(8'(k), 8'(`SOFT_RST_CYC));
    rd(`PWR_DOWN_ADDR, 34'h04);
    rd(`LOOP_MODE_ADDR, {26'h0, 8'h71});
    // unmapped place: ignored write, zero read with error
    bus(1'b1, 14'h2810, 8'hff, 4'h1);
    rd(14'h2810, {2'h2, 32'h0});
    repeat (3) @(posedge ref_clk_i);
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("Error at %0t: notes left %h expected %h", $time, exp_q.size(), 0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
